// ---- verilog/dcs_pkg.sv ----
// Purpose: Shared constants and types for the command-spacing host controller
// Assumes: 100 MHz system clock, 10 ns period
// Notes:   Nanosecond minimums are turned into cycle counts here
package dcs_pkg;

    // System clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 10000;

    // Ceiling division of a time in ps by the clock period, at least one
    function automatic int unsigned dcs_cycles(input int unsigned t_ps);
        int unsigned c;
        c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Cycle floor applies only above 6 ns period
    localparam int unsigned FLOOR_APPLIES_PS = 6000;
    function automatic int unsigned dcs_gap(input int unsigned t_ps,
                                            input int unsigned min_ck);
        int unsigned c;
        c = dcs_cycles(t_ps);
        if (CLK_PERIOD_PS > FLOOR_APPLIES_PS && c < min_ck) begin
            c = min_ck;
        end
        return c;
    endfunction

    // Times in picoseconds, as printed; deep sleep minimum in microseconds
    localparam int unsigned SELF_REFRESH_MIN_LOW_PS = 15000;
    localparam int unsigned ALL_BANK_REFRESH_CYCLE_PS = 130000;
    localparam int unsigned SELF_REFRESH_EXIT_PS = 130000 + 10000;
    localparam int unsigned POWER_DOWN_EXIT_GAP_PS = 7500;
    localparam int unsigned WRITE_TO_READ_GAP_PS = 7500;
    localparam int unsigned READ_TO_PRECHARGE_GAP_PS = 7500;
    localparam int unsigned SINGLE_BANK_PRECHARGE_PS = 18000;
    localparam int unsigned ALL_BANK_PRECHARGE_PS = 21000;
    localparam int unsigned CROSS_BANK_ACTIVATE_PS = 10000;
    localparam int unsigned ROW_OPEN_TIME_PS = 42000;
    localparam int unsigned DEEP_SLEEP_MIN_US = 500;
    localparam int unsigned BOOT_CLOCK_PERIOD_MIN_PS = 18000;
    localparam int unsigned BOOT_CLOCK_PERIOD_MAX_PS = 100000;

    // Counts in clock cycles
    localparam int unsigned CKE_MIN_PULSE_CK = 3;
    localparam int unsigned MODE_READ_GAP_CK = 2;
    localparam int unsigned MODE_WRITE_GAP_CK = 5;
    localparam int unsigned SR_LOW_CK = dcs_gap(SELF_REFRESH_MIN_LOW_PS, 3);
    localparam int unsigned SR_EXIT_CK = dcs_gap(SELF_REFRESH_EXIT_PS, 2);
    localparam int unsigned PD_EXIT_CK = dcs_gap(POWER_DOWN_EXIT_GAP_PS, 2);
    localparam int unsigned WTR_CK = dcs_gap(WRITE_TO_READ_GAP_PS, 2);
    localparam int unsigned RTP_CK = dcs_gap(READ_TO_PRECHARGE_GAP_PS, 2);
    localparam int unsigned RP_PB_CK = dcs_gap(SINGLE_BANK_PRECHARGE_PS, 3);
    localparam int unsigned RP_AB_CK = dcs_gap(ALL_BANK_PRECHARGE_PS, 3);
    localparam int unsigned RRD_CK = dcs_gap(CROSS_BANK_ACTIVATE_PS, 2);
    localparam int unsigned RAS_CK = dcs_gap(ROW_OPEN_TIME_PS, 3);
    localparam int unsigned DPD_CK = DEEP_SLEEP_MIN_US * 1000000
                                     / CLK_PERIOD_PS;
    // Boot clock divider: half period in system cycles (20 ns cycle)
    localparam int unsigned BOOT_HALF_CK =
        (BOOT_CLOCK_PERIOD_MIN_PS + 2 * CLK_PERIOD_PS - 1)
        / (2 * CLK_PERIOD_PS);
    // Strobe first edge one cycle after write latency: inside 0.75..1.25
    localparam int unsigned STROBE_FIRST_EDGE_CK = 1;

    // Width of every gap counter
    localparam int unsigned GAP_W = 16;

    // Commands accepted from the user side
    typedef enum logic [3:0] {
        DCS_NOP = 4'h0,
        DCS_ACT = 4'h1,
        DCS_RD = 4'h2,
        DCS_WR = 4'h3,
        DCS_PRE = 4'h4,
        DCS_PREA = 4'h5,
        DCS_REF = 4'h6,
        DCS_MRR = 4'h7,
        DCS_MRW = 4'h8,
        DCS_SRE = 4'h9,
        DCS_PDE = 4'hA,
        DCS_DPDE = 4'hB,
        DCS_EXIT = 4'hC,
        DCS_RESET = 4'hD
    } dcs_cmd_t;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        DCS_ST_ACTIVE = 4'b0001,
        DCS_ST_SREF = 4'b0010,
        DCS_ST_PDOWN = 4'b0100,
        DCS_ST_DPD = 4'b1000
    } dcs_state_t;

    // Request carried from the user
    typedef struct packed {
        dcs_cmd_t cmd;
        logic [2:0] bank;
    } dcs_req_t;

    // Command issued to the memory
    typedef struct packed {
        logic valid;
        dcs_cmd_t cmd;
        logic [2:0] bank;
    } dcs_issue_t;

endpackage : dcs_pkg

// ---- verilog/dcs_host.sv ----
// Purpose: Host-side command spacing for a low-power DDR2 memory
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Holds each command until its spacing gaps have run out (all-bank precharge skips the read-to-precharge gap);
//          device output timing and derating are outside this block
//////////////////////////////////////////////////////////////////////////////
module dcs_host
    import dcs_pkg::*;
#(
    parameter int unsigned DPD_CYCLES = DPD_CK,
    parameter int unsigned NBANK = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // User request side
    input wire logic req_valid_in,
    input wire dcs_req_t req_in,
    input wire logic boot_done_in,
    output logic req_ready_out,
    // Memory side
    output dcs_issue_t mem_cmd_out,
    output logic mem_cke_out,
    output logic mem_ck_out,
    output logic strobe_out,
    output logic strobe_oe_out
);

    //////////////////////////////////////////////////////////////////////////
    // All state of the module
    // Bank counters are kept per bank; NBANK sets how many
    typedef struct packed {
        dcs_state_t st;
        logic [GAP_W-1:0] cmd_gap;        // Any-command gap
        logic [GAP_W-1:0] rd_gap;         // Before next read
        logic [GAP_W-1:0] act_gap;        // Before activate, any bank
        logic [NBANK-1:0][GAP_W-1:0] bank_act; // Same-bank activate
        logic [NBANK-1:0][GAP_W-1:0] bank_pre; // Bank precharge
        logic [NBANK-1:0][GAP_W-1:0] bank_cmd; // Activate, read or write to bank
        logic [NBANK-1:0][GAP_W-1:0] row_open; // Row open time
        logic [GAP_W-1:0] cke_hold;       // Clock enable level age
        logic [31:0] dpd_cnt;             // Deep power-down dwell
        logic [3:0] boot_div;             // Boot clock divider
        logic [2:0] wstrb;                // Write strobe sequencer
        logic ready;
        dcs_issue_t issue;
        logic cke;
        logic ck;
        logic strobe;
        logic strobe_oe;
    } dcs_regs_t;

    dcs_regs_t state_reg;
    dcs_regs_t state_next;

    // Decrement toward zero
    function automatic logic [GAP_W-1:0] dec(input logic [GAP_W-1:0] v);
        return (v == '0) ? v : v - 16'h0001;
    endfunction

    // Larger of a running gap and a new demand
    function automatic logic [GAP_W-1:0] lift(input logic [GAP_W-1:0] v,
                                               input int unsigned n);
        logic [GAP_W-1:0] n_w;
        n_w = GAP_W'(n);
        return (n_w > v) ? n_w : v;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Acceptance check and next state
    always_comb begin
        logic ok;
        logic [2:0] b;
        state_next = state_reg;
        ok = 1'b0;
        b = req_in.bank;

        // Counters run down every cycle
        // A gap loaded with N lets the next command out N+1 cycles on:
        // one spare cycle per gap buys a plain compare against zero
        state_next.cmd_gap = dec(state_reg.cmd_gap);
        state_next.rd_gap = dec(state_reg.rd_gap);
        state_next.act_gap = dec(state_reg.act_gap);
        for (int i = 0; i < NBANK; i++) begin
            state_next.bank_act[i] = dec(state_reg.bank_act[i]);
            state_next.bank_pre[i] = dec(state_reg.bank_pre[i]);
            state_next.bank_cmd[i] = dec(state_reg.bank_cmd[i]);
            state_next.row_open[i] = dec(state_reg.row_open[i]);
        end
        if (state_reg.cke_hold != '0) begin
            state_next.cke_hold = dec(state_reg.cke_hold);
        end
        if (state_reg.dpd_cnt != 32'h0) begin
            state_next.dpd_cnt = state_reg.dpd_cnt - 32'h00000001;
        end
        // Command pulse lasts a single cycle
        state_next.issue = '0;

        // Boot clock toggles every BOOT_HALF_CK cycles until configured, every cycle after
        // The boot half period is a package count; raise it to slow boot
        if (!boot_done_in) begin
            if (state_reg.boot_div == 4'(BOOT_HALF_CK - 1)) begin
                state_next.boot_div = 4'h0;
                state_next.ck = ~state_reg.ck;
            end else begin
                state_next.boot_div = state_reg.boot_div + 4'h1;
            end
        end else begin
            state_next.boot_div = 4'h0;
            state_next.ck = ~state_reg.ck;
        end

        // Write strobe: idle, wait, high, low, done
        case (state_reg.wstrb)
            3'h1: begin
                state_next.wstrb = 3'h2;
                state_next.strobe = 1'b1;
            end
            3'h2: begin
                state_next.wstrb = 3'h3;
                state_next.strobe = 1'b0;
            end
            3'h3: begin
                state_next.wstrb = 3'h0;
                state_next.strobe_oe = 1'b0;
                // Write data ends here; read spacing counts from it.
                // Overwrites the hold set at the write command, which is huge
                state_next.rd_gap = GAP_W'(WTR_CK);
            end
            default: begin
                state_next.wstrb = 3'h0;
            end
        endcase

        // Gap checks per command; counts already rounded up
        if (state_reg.cmd_gap == '0) begin
            case (state_reg.st)
                DCS_ST_ACTIVE: begin
                    case (req_in.cmd)
                        DCS_ACT: ok = state_reg.act_gap == '0 &&
                                      state_reg.bank_act[b] == '0 &&
                                      state_reg.bank_cmd[b] == '0;
                        DCS_RD: ok = state_reg.rd_gap == '0 &&
                                     state_reg.bank_cmd[b] == '0;
                        DCS_WR: ok = state_reg.wstrb == 3'h0 &&
                                     state_reg.bank_cmd[b] == '0;
                        DCS_PRE: ok = state_reg.bank_pre[b] == '0 &&
                                      state_reg.row_open[b] == '0;
                        DCS_PREA: begin
                            // Every open row must have stayed open long enough
                            ok = 1'b1;
                            for (int i = 0; i < NBANK; i++) begin
                                if (state_reg.row_open[i] != '0) begin
                                    ok = 1'b0;
                                end
                            end
                        end
                        // Power entries wait out the last clock enable change
                        DCS_SRE, DCS_PDE, DCS_DPDE:
                            ok = state_reg.cke_hold == '0;
                        DCS_NOP: ok = 1'b0;
                        default: ok = 1'b1;
                    endcase
                end
                // In low power only an exit is taken; all else waits
                // Exits only after minimum dwell and clock enable age
                DCS_ST_SREF, DCS_ST_PDOWN: begin
                    ok = req_in.cmd == DCS_EXIT &&
                         state_reg.cke_hold == '0;
                end
                DCS_ST_DPD: begin
                    ok = req_in.cmd == DCS_EXIT &&
                         state_reg.dpd_cnt == 32'h0 &&
                         state_reg.cke_hold == '0;
                end
                default: ok = 1'b0;
            endcase
        end
        // Nothing reaches the memory before it is configured;
        // a held request simply waits, no error is raised
        ok = ok && req_valid_in && boot_done_in;

        // Issue and arm the gaps that follow it
        if (ok) begin
            state_next.issue = {1'b1, req_in.cmd, b};
            case (req_in.cmd)
                DCS_ACT: begin
                    state_next.act_gap = GAP_W'(RRD_CK);
                    // Row time plus precharge; precharge gap adds later
                    state_next.bank_act[b] = GAP_W'(RAS_CK);
                    state_next.row_open[b] = GAP_W'(RAS_CK);
                    state_next.cmd_gap = 16'h0001;
                end
                DCS_RD: begin
                    state_next.bank_pre[b] = lift(state_next.bank_pre[b],
                                                  RTP_CK);
                    state_next.cmd_gap = 16'h0001;
                end
                DCS_WR: begin
                    state_next.wstrb = 3'h1;
                    state_next.strobe_oe = 1'b1;
                    state_next.strobe = 1'b0;
                    state_next.rd_gap = GAP_W'(16'hFFFF);
                    state_next.cmd_gap = 16'h0001;
                end
                DCS_PRE: begin
                    state_next.bank_cmd[b] = GAP_W'(RP_PB_CK);
                    state_next.bank_act[b] = lift(state_next.bank_act[b],
                                                  RP_PB_CK);
                    state_next.cmd_gap = 16'h0001;
                end
                DCS_PREA: begin
                    for (int i = 0; i < NBANK; i++) begin
                        state_next.bank_act[i] = lift(state_next.bank_act[i],
                                                      RP_AB_CK);
                    end
                    state_next.act_gap = lift(state_next.act_gap,
                                              RP_AB_CK);
                    state_next.cmd_gap = GAP_W'(RP_AB_CK);
                end
                DCS_MRR: state_next.cmd_gap = GAP_W'(MODE_READ_GAP_CK);
                DCS_MRW: state_next.cmd_gap = GAP_W'(MODE_WRITE_GAP_CK);
                DCS_SRE: begin
                    state_next.st = DCS_ST_SREF;
                    state_next.cke = 1'b0;
                    state_next.cke_hold = GAP_W'(SR_LOW_CK);
                end
                DCS_PDE: begin
                    state_next.st = DCS_ST_PDOWN;
                    state_next.cke = 1'b0;
                    state_next.cke_hold = GAP_W'(CKE_MIN_PULSE_CK);
                end
                DCS_DPDE: begin
                    state_next.st = DCS_ST_DPD;
                    state_next.cke = 1'b0;
                    state_next.cke_hold = GAP_W'(CKE_MIN_PULSE_CK);
                    state_next.dpd_cnt = DPD_CYCLES;
                end
                DCS_EXIT: begin
                    state_next.st = DCS_ST_ACTIVE;
                    state_next.cke = 1'b1;
                    state_next.cke_hold = GAP_W'(CKE_MIN_PULSE_CK);
                    if (state_reg.st == DCS_ST_SREF) begin
                        state_next.cmd_gap = GAP_W'(SR_EXIT_CK);
                    end else begin
                        state_next.cmd_gap = GAP_W'(PD_EXIT_CK);
                    end
                end
                // Reset lets the device restore mode defaults
                default: state_next.cmd_gap = 16'h0001;
            endcase
        end
        // Ready is set in the register process from the issue pulse
        state_next.ready = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // State register; floors folded in the package
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_reg <= '0;
            state_reg.st <= DCS_ST_ACTIVE;
            state_reg.cke <= 1'b1;
            // Clock enable starts high and keeps it for the minimum pulse
            state_reg.cke_hold <= GAP_W'(CKE_MIN_PULSE_CK);
        end else begin
            state_reg <= state_next;
            state_reg.ready <= state_next.issue.valid;
        end
    end

    // Outputs come straight from the state register
    // Ready rises with the command pulse, in the same cycle
    // Strobe enable spans the whole strobe sequence of a write
    assign req_ready_out = state_reg.ready;
    assign mem_cmd_out = state_reg.issue;
    assign mem_cke_out = state_reg.cke;
    assign mem_ck_out = state_reg.ck;
    assign strobe_out = state_reg.strobe;
    assign strobe_oe_out = state_reg.strobe_oe;

endmodule // dcs_host

// ---- verification/dcs_host_properties.sv ----
// Purpose: Spacing and pin checks on the host command port
// Assumes: One clock domain, sync active-high reset
// Notes:   Gaps are counted between issued command pulses
module dcs_host_properties
    import dcs_pkg::*;
#(
    parameter int unsigned DPD_CYCLES = DPD_CK
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // Watched ports
    input wire logic boot_done_in,
    input wire dcs_issue_t mem_cmd_out,
    input wire logic mem_cke_out,
    input wire logic mem_ck_out,
    input wire logic strobe_out,
    input wire logic strobe_oe_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    // Command of one kind issued this cycle
    function automatic logic hit(dcs_issue_t c, dcs_cmd_t k);
        return c.valid && (c.cmd == k);
    endfunction

    dcs_issue_t p1_reg; // Command one cycle back
    dcs_issue_t p2_reg; // Command two cycles back
    logic sref_reg; // Inside self refresh
    logic dpd_reg; // Inside deep power-down
    logic [31:0] dpd_cnt_reg; // Cycles since deep power-down entry

    ////////////////////////////////////////
    // History, so bank gaps need no local variables
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            p1_reg <= '0;
            p2_reg <= '0;
            sref_reg <= 1'b0;
            dpd_reg <= 1'b0;
            dpd_cnt_reg <= '0;
        end else begin
            p1_reg <= mem_cmd_out;
            p2_reg <= p1_reg;
            sref_reg <= hit(mem_cmd_out, DCS_SRE)
                | (sref_reg & !hit(mem_cmd_out, DCS_EXIT));
            dpd_reg <= hit(mem_cmd_out, DCS_DPDE)
                | (dpd_reg & !hit(mem_cmd_out, DCS_EXIT));
            dpd_cnt_reg <= hit(mem_cmd_out, DCS_DPDE) ? 32'h1
                : dpd_cnt_reg + 32'h1;
        end
    end

    ////////////////////////////////////////
    a_strobe_place: assert property (hit(mem_cmd_out, DCS_WR) |->
        strobe_oe_out && !strobe_out ##1 strobe_oe_out && strobe_out
        ##1 !strobe_out) else $error("write strobe misplaced");
    a_cke_hold: assert property ($changed(mem_cke_out) |=>
        $stable(mem_cke_out) [*2]) else $error("clock enable pulse short");
    a_mrr_gap: assert property (hit(mem_cmd_out, DCS_MRR) |=>
        !mem_cmd_out.valid) else $error("mode read gap short");
    a_mrw_gap: assert property (hit(mem_cmd_out, DCS_MRW) |=>
        !mem_cmd_out.valid [*4]) else $error("mode write gap short");
    a_sref_exit: assert property (hit(mem_cmd_out, DCS_EXIT) && sref_reg
        |=> !mem_cmd_out.valid [*8] ##1 !mem_cmd_out.valid [*5])
        else $error("self refresh exit gap short");
    a_pd_exit: assert property (hit(mem_cmd_out, DCS_EXIT) && !sref_reg
        |=> !mem_cmd_out.valid) else $error("power-down exit gap short");
    a_dpd_stay: assert property (hit(mem_cmd_out, DCS_EXIT) && dpd_reg
        |-> dpd_cnt_reg >= DPD_CYCLES) else $error("deep sleep too short");
    a_wr_to_rd: assert property (hit(mem_cmd_out, DCS_WR) |=>
        !hit(mem_cmd_out, DCS_RD) [*3]) else $error("read after write early");
    a_rd_to_pre: assert property (hit(mem_cmd_out, DCS_RD) |=>
        !hit(mem_cmd_out, DCS_PRE) && !hit(mem_cmd_out, DCS_PREA))
        else $error("precharge after read early");
    a_pre_bank: assert property (mem_cmd_out.valid |->
        !(hit(p1_reg, DCS_PRE) && p1_reg.bank == mem_cmd_out.bank)
        && !(hit(p2_reg, DCS_PRE) && p2_reg.bank == mem_cmd_out.bank))
        else $error("bank used too soon after precharge");
    a_prea_gap: assert property (hit(mem_cmd_out, DCS_PREA) |=>
        !(hit(mem_cmd_out, DCS_ACT) || hit(mem_cmd_out, DCS_REF)) [*2])
        else $error("all-bank precharge gap short");
    a_act_act: assert property (hit(mem_cmd_out, DCS_ACT) |=>
        !hit(mem_cmd_out, DCS_ACT)) else $error("activates too close");
    a_boot_clk: assert property (!$past(srst_in) |->
        mem_ck_out != $past(mem_ck_out)) else $error("memory clock stalled");
    a_boot_quiet: assert property (!$past(boot_done_in) |->
        !mem_cmd_out.valid) else $error("command during boot");

    // Main scenarios reached
    c_write: cover property (hit(mem_cmd_out, DCS_WR));
    c_sref: cover property (hit(mem_cmd_out, DCS_EXIT) && sref_reg);
    c_dpd: cover property (hit(mem_cmd_out, DCS_EXIT) && dpd_reg);
endmodule // dcs_host_properties

bind dcs_host dcs_host_properties #(.DPD_CYCLES(DPD_CYCLES)) u_props (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .boot_done_in(boot_done_in),
    .mem_cmd_out(mem_cmd_out),
    .mem_cke_out(mem_cke_out),
    .mem_ck_out(mem_ck_out),
    .strobe_out(strobe_out),
    .strobe_oe_out(strobe_oe_out)
);

// ---- verification/dcs_mem_model.sv ----
// Purpose: Behavioural memory device behind the host port
// Assumes: Commands arrive as one-cycle pulses
// Notes:   Keeps one mode register; its write data rides the bank field
module dcs_mem_model
    import dcs_pkg::*;
#(
    parameter logic [7:0] MR_DEFAULT = 8'h00 // Plain default value
) (
    // Clock and reset
    input wire logic ck_in,
    input wire logic srst_in,
    // Command bus
    input wire dcs_issue_t cmd_in,
    output logic [7:0] mode_reg_out
);
    ////////////////////////////////////////
    // Mode register; power-up state matches a reset command
    always_ff @(posedge ck_in) begin
        if (srst_in || (cmd_in.valid && cmd_in.cmd == DCS_RESET)) begin
            mode_reg_out <= MR_DEFAULT;
        end else if (cmd_in.valid && cmd_in.cmd == DCS_MRW) begin
            mode_reg_out <= {5'h00, cmd_in.bank};
        end
    end
endmodule // dcs_mem_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the command spacing host
// Assumes: 100 MHz clock; short deep power-down count
// Notes:   Gaps are measured between issued command pulses
module tb_top
    import dcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DPD_SIM = 20; // Shortened deep sleep count
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic req_valid_in = 1'b0;
    dcs_req_t req_in = '0;
    logic boot_done_in = 1'b0;
    logic req_ready_out, mem_cke_out, mem_ck_out, strobe_out, strobe_oe_out;
    dcs_issue_t mem_cmd_out;
    logic [7:0] mode_reg; // Device mode register
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0; // Cycle count, also the hang limit
    int t_prev, t_now, t0; // Issue cycles
    logic [15:0] lfsr = 16'h285A; // Seed 10330
    logic [2:0] ba; // Random bank

    dcs_host #(.DPD_CYCLES(DPD_SIM)) dut (.ref_clk_in(ref_clk_in),
        .srst_in(srst_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .boot_done_in(boot_done_in), .req_ready_out(req_ready_out),
        .mem_cmd_out(mem_cmd_out), .mem_cke_out(mem_cke_out),
        .mem_ck_out(mem_ck_out), .strobe_out(strobe_out),
        .strobe_oe_out(strobe_oe_out));
    dcs_mem_model u_mem (.ck_in(ref_clk_in), .srst_in(srst_in),
        .cmd_in(mem_cmd_out), .mode_reg_out(mode_reg));

    ////////////////////////////////////////
    always #5 ref_clk_in = ~ref_clk_in;
    // Hang guard
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // Minimum gap in cycles, rounded up; floor only above 6 ns period
    function automatic int need(input int ps, input int ck);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (CLK_PERIOD_PS > 6000 && c < ck) ? ck : c;
    endfunction
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Gap counters release one cycle past each minimum spacing
    task automatic gap(input string what, input int e);
        chk(what, 16'(e + 1), 16'(t_now - t_prev));
    endtask
    task automatic gap_ge(input string what, input int e);
        chk(what, 16'h1, {15'h0, (t_now - t_prev) >= e});
    endtask
    // Hold a request until its command pulse shows
    task automatic issue(input dcs_cmd_t c, input logic [2:0] b);
        int n;
        // Let an edge pass so valid never drops and rises at once
        @(posedge ref_clk_in);
        #1;
        req_in = '{cmd: c, bank: b};
        req_valid_in = 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end while (mem_cmd_out.valid !== 1'b1 && n < 100);
        req_valid_in = 1'b0;
        t_prev = t_now;
        t_now = cyc;
        chk("issued cmd", {11'h0, 1'b1, c},
            {11'h0, mem_cmd_out.valid, mem_cmd_out.cmd});
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk_in);
        #1 srst_in = 1'b0;
        // Boot: request waits while unconfigured
        req_in = '{cmd: DCS_ACT, bank: 3'h0};
        req_valid_in = 1'b1;
        repeat (8) begin
            @(posedge ref_clk_in);
            #1;
            chk("boot quiet", 16'h0, {15'h0, mem_cmd_out.valid});
        end
        req_valid_in = 1'b0;
        boot_done_in = 1'b1;
        issue(DCS_ACT, 3'h0);
        // Ready pulses together with the command
        chk("ready pulse", 16'h1, {15'h0, req_ready_out});
        $display("test boot done");
        // Mode register and its default
        issue(DCS_RESET, 3'h0);
        issue(DCS_MRW, 3'h5);
        issue(DCS_MRR, 3'h5);
        gap("mode write gap", MODE_WRITE_GAP_CK);
        chk("mode written", 16'h0005, {8'h00, mode_reg});
        issue(DCS_PREA, 3'h0);
        gap("mode read gap", MODE_READ_GAP_CK);
        issue(DCS_RESET, 3'h0);
        @(posedge ref_clk_in);
        #1;
        chk("mode default", 16'h0000, {8'h00, mode_reg});
        $display("test mode done");
        // Bank traffic, awkward back-to-back order
        issue(DCS_ACT, 3'h0);
        t0 = t_now;
        lfsr = step(lfsr);
        issue(DCS_ACT, {lfsr[2:1], 1'b1});
        gap("cross bank act", need(10000, 2));
        issue(DCS_RD, 3'h0);
        issue(DCS_PRE, 3'h0);
        gap("read to pre", need(7500, 2));
        issue(DCS_ACT, 3'h0);
        gap("pre to act", need(18000, 3));
        chk("same bank act", 16'h1, {15'h0, (t_now - t0) >= 8});
        issue(DCS_WR, 3'h0);
        issue(DCS_RD, 3'h0);
        gap_ge("write to read", need(7500, 2) + 2);
        // Random bank pairs after all-bank precharge
        repeat (6) begin
            lfsr = step(lfsr);
            ba = lfsr[2:0];
            issue(DCS_PREA, 3'h0);
            issue(DCS_ACT, ba);
            gap("prea to act", need(21000, 3));
            issue(DCS_ACT, ba ^ {lfsr[4:3], 1'b1});
            gap("pair act", need(10000, 2));
        end
        $display("test banks done");
        // Low-power entries and exits
        issue(DCS_PREA, 3'h0);
        issue(DCS_SRE, 3'h0);
        chk("cke low", 16'h0, {15'h0, mem_cke_out});
        issue(DCS_EXIT, 3'h0);
        gap_ge("sref low", need(15000, 3));
        issue(DCS_REF, 3'h0);
        gap("sref exit", need(130000 + 10000, 2));
        chk("cke high", 16'h1, {15'h0, mem_cke_out});
        issue(DCS_PDE, 3'h0);
        issue(DCS_EXIT, 3'h0);
        issue(DCS_REF, 3'h0);
        gap("pd exit", need(7500, 2));
        issue(DCS_DPDE, 3'h0);
        issue(DCS_EXIT, 3'h0);
        gap_ge("deep sleep", DPD_SIM);
        issue(DCS_REF, 3'h0);
        $display("test power done");
        report_and_stop();
    end
endmodule // tb_top
